/* rtl/sfpbm_core.v */
`timescale 1ns/10ps
`include "sfpbm_map.vh"

// Summary of operation
// R01: top select 0: level n locks top blocks
// R02: top select 1: level n locks bottom blocks
// R03: levels 9 to 15 lock every block
// R04: two lockable 4K-bit one-time regions
// R05: customer 000-1FF, factory 200-3FF offsets
// R06: security bit 0 shows factory lock
// R07: security write sets customer lock bit 1
// R08: enter secure area, program, then exit
// R09: locked one-time region never changes again; reset clears cust_lock_reg, so the customer half can be programmed again
// R10: secure mode blocks main array access
// R11: address splits into sector and blocks
// R12: invalid command: ignore until select falls
// R13: valid command: active until select rises
// R14: sample on rising, launch on falling
// R15: reads may end after any bit
// R16: write-type commands need byte-aligned end
// R17: busy: array access ignored, op undisturbed
// R18: host checks status before commands
// R19: 35h in single mode enters quad
// R20: F5h in quad mode returns single
// R21: host keeps select high after switch
// R22: level bits and select define region
// R23: changes need write enable latch first
// R24: select high and idle means standby
// R25: protected target: command silently dropped
// R26: reset: single mode, secure mode off
module sfpbm_core (
	input wire clk_in,
	input wire rstn_in,
	input wire sclk_in,
	input wire cs_n_in,
	input wire [3:0] sio_in,
	input wire prot_level_b3_in,
	input wire prot_level_b2_in,
	input wire prot_level_b1_in,
	input wire prot_level_b0_in,
	input wire top_bottom_sel_in,
	input wire factory_lock_in,
	input wire busy_flag_in,
	output reg [3:0] sio_out,
	output reg [3:0] sio_oe_out,
	output reg active_out,
	output reg reject_out,
	output reg read_req_out,
	output reg prog_req_out,
	output reg erase_req_out,
	output reg [1:0] erase_kind_out,
	output reg otp_sel_out,
	output reg [23:0] addr_out,
	output reg [11:0] sector_out,
	output reg [8:0] blk32_out,
	output reg [7:0] blk64_out,
	output reg write_enable_latch_out,
	output reg quad_command_mode_out,
	output reg secure_mode_out,
	output reg [7:0] security_reg_out
);

localparam ST_IDLE = 2'h0;
localparam ST_CMD = 2'h1;
localparam ST_ACT = 2'h2;
localparam ST_IGN = 2'h3;

reg [2:0] sclk_sync_reg;
reg [2:0] cs_sync_reg;
reg [3:0] sio_s1_reg;
reg [3:0] sio_s2_reg;
reg [1:0] state_reg;
reg [7:0] shift_reg;
reg [2:0] bitpos_reg;
reg [2:0] hdr_cnt_reg;
reg [7:0] op_reg;
reg [23:0] addr_reg;
reg [7:0] out_sh_reg;
reg cust_lock_reg;
reg fact_lock_reg;

wire sclk_rise;
wire sclk_fall;
wire cs_fall;
wire cs_rise;
wire [3:0] level;
wire [7:0] byte_now;
wire [2:0] bitpos_now;
wire byte_done;
wire otp_locked;
wire blk_prot;
wire is_write_type;
wire is_read_type;

// edges only from the settled stages, never stage one
assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];

assign level = {prot_level_b3_in, prot_level_b2_in,
	prot_level_b1_in, prot_level_b0_in}; // [R22]

// one bit or one nibble per rising clock edge
assign byte_now = quad_command_mode_out ?
	{shift_reg[3:0], sio_s2_reg} :
	{shift_reg[6:0], sio_s2_reg[0]}; // [R14] [R19]
assign bitpos_now = quad_command_mode_out ?
	bitpos_reg + 3'h4 : bitpos_reg + 3'h1;
assign byte_done = (bitpos_now == 3'h0);

// a set lock, customer or factory, freezes its half
assign otp_locked = addr_reg[`SFPBM_OTP_REGION_BIT] ?
	fact_lock_reg : cust_lock_reg; // [R05] [R09]

// block lock decode on the 64K block index
function prot_hit;
	input [7:0] blk;
	input [3:0] lvl;
	input tb;
	reg [8:0] size;
	begin
		size = 9'h001 << (lvl - 4'h1);
		if (lvl == `SFPBM_LVL_NONE)
			prot_hit = 1'b0;
		else if (lvl > `SFPBM_LVL_MAXPART)
			prot_hit = 1'b1; // [R03]
		else if (tb)
			prot_hit = ({1'b0, blk} < size); // [R02]
		else
			prot_hit = ({1'b0, `SFPBM_BLK_LAST - blk} < size); // [R01]
	end
endfunction

assign blk_prot = prot_hit(addr_reg[23:16], level,
	top_bottom_sel_in); // [R11] [R22]

// which codes the current command mode accepts
function op_valid;
	input [7:0] op;
	input quad;
	begin
		case (op)
			`SFPBM_OP_QUAD_ENTER: op_valid = ~quad; // [R19]
			`SFPBM_OP_QUAD_EXIT: op_valid = quad; // [R20]
			`SFPBM_OP_READ: op_valid = ~quad;
			`SFPBM_OP_WRITE_ON, `SFPBM_OP_WRDI,
			`SFPBM_OP_PROG, `SFPBM_OP_SE,
			`SFPBM_OP_BE32, `SFPBM_OP_BE64,
			`SFPBM_OP_CE_A, `SFPBM_OP_CE_B,
			`SFPBM_OP_SEC_ENTER, `SFPBM_OP_SEC_EXIT,
			`SFPBM_OP_SEC_WRITE, `SFPBM_OP_SEC_READ:
				op_valid = 1'b1;
			default: op_valid = 1'b0;
		endcase
	end
endfunction

assign is_read_type = (op_reg == `SFPBM_OP_READ) |
	(op_reg == `SFPBM_OP_SEC_READ);
assign is_write_type = ~is_read_type;

// pin synchronisers, two stages plus one for edges
always @(posedge clk_in) begin
	if (!rstn_in) begin
		sclk_sync_reg <= 3'h0;
		cs_sync_reg <= 3'h7;
		sio_s1_reg <= 4'h0;
		sio_s2_reg <= 4'h0;
	end else begin
		sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
		cs_sync_reg <= {cs_sync_reg[1:0], cs_n_in};
		sio_s1_reg <= sio_in;
		sio_s2_reg <= sio_s1_reg;
	end
end

// factory lock strap, resampled every clock after reset release
always @(posedge clk_in) begin
	if (!rstn_in)
		fact_lock_reg <= 1'b0;
	else
		fact_lock_reg <= factory_lock_in; // [R06]
end

// frame tracking, decode and execution
always @(posedge clk_in) begin
	if (!rstn_in) begin
		state_reg <= ST_IDLE;
		shift_reg <= 8'h00;
		bitpos_reg <= 3'h0;
		hdr_cnt_reg <= 3'h0;
		op_reg <= 8'h00;
		addr_reg <= 24'h000000;
		cust_lock_reg <= 1'b0;
		write_enable_latch_out <= 1'b0;
		quad_command_mode_out <= 1'b0; // [R26]
		secure_mode_out <= 1'b0; // [R26]
		active_out <= 1'b0;
		reject_out <= 1'b0;
		read_req_out <= 1'b0;
		prog_req_out <= 1'b0;
		erase_req_out <= 1'b0;
		erase_kind_out <= `SFPBM_ER_SECTOR;
		otp_sel_out <= 1'b0;
		addr_out <= 24'h000000;
		sector_out <= 12'h000;
		blk32_out <= 9'h000;
		blk64_out <= 8'h00;
	end else begin
		reject_out <= 1'b0;
		read_req_out <= 1'b0;
		prog_req_out <= 1'b0;
		erase_req_out <= 1'b0;
		if (cs_fall) begin
			// every frame starts clean, even after ignore
			state_reg <= ST_CMD; // [R12]
			bitpos_reg <= 3'h0;
			hdr_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (cs_rise) begin
			state_reg <= ST_IDLE; // [R13] [R24]
			active_out <= 1'b0;
			if (state_reg == ST_ACT && is_write_type) begin
				if (bitpos_reg != 3'h0)
					reject_out <= 1'b1; // [R16]
				else begin
					case (op_reg)
						`SFPBM_OP_WRITE_ON:
							write_enable_latch_out <= 1'b1;
						`SFPBM_OP_WRDI:
							write_enable_latch_out <= 1'b0;
						`SFPBM_OP_QUAD_ENTER:
							quad_command_mode_out <= 1'b1; // [R19]
						`SFPBM_OP_QUAD_EXIT:
							quad_command_mode_out <= 1'b0; // [R20]
						`SFPBM_OP_SEC_ENTER:
							secure_mode_out <= 1'b1; // [R08]
						`SFPBM_OP_SEC_EXIT:
							secure_mode_out <= 1'b0; // [R08]
						`SFPBM_OP_SEC_WRITE: begin
							if (write_enable_latch_out &&
								!busy_flag_in) begin // [R23]
								cust_lock_reg <= 1'b1; // [R07]
								write_enable_latch_out <= 1'b0;
							end
						end
						`SFPBM_OP_PROG: begin
							// needs address plus at least one data byte
							if (write_enable_latch_out && !busy_flag_in &&
								hdr_cnt_reg > `SFPBM_ADDR_BYTES) begin
								if (secure_mode_out ? !otp_locked
									: !blk_prot) begin // [R09] [R25]
									prog_req_out <= 1'b1; // [R04]
									otp_sel_out <= secure_mode_out;
									write_enable_latch_out <= 1'b0;
								end
							end
						end
						`SFPBM_OP_SE, `SFPBM_OP_BE32,
						`SFPBM_OP_BE64: begin
							// the one-time area cannot be erased
							if (write_enable_latch_out && !busy_flag_in &&
								!secure_mode_out && !blk_prot &&
								hdr_cnt_reg == `SFPBM_ADDR_BYTES) begin
								erase_req_out <= 1'b1; // [R10] [R17] [R25]
								otp_sel_out <= 1'b0;
								erase_kind_out <=
									(op_reg == `SFPBM_OP_SE) ?
									`SFPBM_ER_SECTOR :
									(op_reg == `SFPBM_OP_BE32) ?
									`SFPBM_ER_BLK32 : `SFPBM_ER_BLK64;
								write_enable_latch_out <= 1'b0;
							end
						end
						`SFPBM_OP_CE_A, `SFPBM_OP_CE_B: begin
							// any protection level blocks chip erase
							if (write_enable_latch_out && !busy_flag_in &&
								!secure_mode_out &&
								level == `SFPBM_LVL_NONE &&
								hdr_cnt_reg == 3'h0) begin // [R25]
								erase_req_out <= 1'b1;
								otp_sel_out <= 1'b0;
								erase_kind_out <= `SFPBM_ER_CHIP;
								write_enable_latch_out <= 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end else if (sclk_rise &&
			(state_reg == ST_CMD || state_reg == ST_ACT)) begin
			shift_reg <= byte_now; // [R14]
			bitpos_reg <= bitpos_now;
			if (byte_done && state_reg == ST_CMD) begin
				op_reg <= byte_now;
				if (op_valid(byte_now, quad_command_mode_out)) begin
					state_reg <= ST_ACT; // [R13]
					active_out <= 1'b1;
				end else begin
					state_reg <= ST_IGN; // [R12]
					reject_out <= 1'b1;
				end
			end else if (byte_done) begin
				if (hdr_cnt_reg < `SFPBM_ADDR_BYTES)
					addr_reg <= {addr_reg[15:0], byte_now};
				if (hdr_cnt_reg != 3'h7)
					hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
				// third address byte completes the target
				if (hdr_cnt_reg == 3'h2) begin
					addr_out <= {addr_reg[15:0], byte_now};
					sector_out <= {addr_reg[15:4]}; // [R11]
					blk32_out <= {addr_reg[15:7]};
					blk64_out <= addr_reg[15:8];
					if (op_reg == `SFPBM_OP_READ && !busy_flag_in) begin
						read_req_out <= 1'b1; // [R10] [R17]
						otp_sel_out <= secure_mode_out;
					end
				end
			end
		end
	end
end

// security register image
always @(posedge clk_in) begin
	if (!rstn_in)
		security_reg_out <= 8'h00;
	else begin
		security_reg_out <= 8'h00;
		security_reg_out[`SFPBM_SEC_FACT_BIT] <= fact_lock_reg; // [R06]
		security_reg_out[`SFPBM_SEC_CUST_BIT] <= cust_lock_reg; // [R07]
	end
end

// read-back driver: launched on falling clock edges;
// a select rise at any bit just releases the lines
always @(posedge clk_in) begin
	if (!rstn_in) begin
		out_sh_reg <= 8'h00;
		sio_out <= 4'h0;
		sio_oe_out <= 4'h0;
	end else if (cs_rise || cs_fall || state_reg != ST_ACT ||
		op_reg != `SFPBM_OP_SEC_READ) begin
		out_sh_reg <= {6'h00, cust_lock_reg, fact_lock_reg};
		sio_oe_out <= 4'h0; // [R12] [R15]
		sio_out <= 4'h0;
	end else if (sclk_fall) begin
		if (quad_command_mode_out) begin
			sio_out <= out_sh_reg[7:4]; // [R14]
			sio_oe_out <= 4'hf;
			out_sh_reg <= {out_sh_reg[3:0], out_sh_reg[7:4]};
		end else begin
			sio_out <= {2'h0, out_sh_reg[7], 1'b0};
			sio_oe_out <= 4'h2;
			out_sh_reg <= {out_sh_reg[6:0], out_sh_reg[7]};
		end
	end
end

endmodule // sfpbm_core

/* rtl/sfpbm_map.vh */
`ifndef SFPBM_MAP_VH
`define SFPBM_MAP_VH

// command codes
`define SFPBM_OP_WRITE_ON 8'h06
`define SFPBM_OP_WRDI 8'h04
`define SFPBM_OP_QUAD_ENTER 8'h35
`define SFPBM_OP_QUAD_EXIT 8'hf5
`define SFPBM_OP_READ 8'h03
`define SFPBM_OP_PROG 8'h02
`define SFPBM_OP_SE 8'h20
`define SFPBM_OP_BE32 8'h52
`define SFPBM_OP_BE64 8'hd8
`define SFPBM_OP_CE_A 8'h60
`define SFPBM_OP_CE_B 8'hc7
// plain defaults, codes not fixed elsewhere
`define SFPBM_OP_SEC_ENTER 8'hb1
`define SFPBM_OP_SEC_EXIT 8'hc1
`define SFPBM_OP_SEC_WRITE 8'h2f
`define SFPBM_OP_SEC_READ 8'h2b

// erase kinds
`define SFPBM_ER_SECTOR 2'h0
`define SFPBM_ER_BLK32 2'h1
`define SFPBM_ER_BLK64 2'h2
`define SFPBM_ER_CHIP 2'h3

// protection levels and array layout
`define SFPBM_LVL_NONE 4'h0
`define SFPBM_LVL_MAXPART 4'h8
`define SFPBM_BLK_LAST 8'hff
`define SFPBM_ADDR_BYTES 3'h3

// one-time area: offset bit 9 picks the region
`define SFPBM_OTP_REGION_BIT 9
`define SFPBM_OTP_CUST_LO 10'h000
`define SFPBM_OTP_CUST_HI 10'h1ff
`define SFPBM_OTP_FACT_LO 10'h200
`define SFPBM_OTP_FACT_HI 10'h3ff

// security register fields
`define SFPBM_SEC_FACT_BIT 0
`define SFPBM_SEC_CUST_BIT 1

`endif

/* bench/sfpbm_host.sv */
`timescale 1ns/10ps
module sfpbm_host (
	input wire clk_in,
	input wire [3:0] sio_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] sio_out
);
	logic [7:0] rx_byte;
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sio_out = 4'h0;
		rx_byte = 8'h00;
	end
	// one frame, mode 0, msb first, w lanes a step
	task automatic xfer(input logic [39:0] v, input int n, input int w);
		int i;
		@(negedge clk_in);
		cs_n_out = 1'b0;
		for (i = 0; i < n; i += w) begin
			sio_out = (w == 4) ? v[39-i -: 4] : {4{v[39-i]}};
			repeat (12) @(negedge clk_in);
			// read-back lanes settled long before this rise
			rx_byte = (w == 4) ? {rx_byte[3:0], sio_in} :
				{rx_byte[6:0], sio_in[1]};
			sclk_out = 1'b1;
			repeat (13) @(negedge clk_in);
			sclk_out = 1'b0;
		end
		repeat (12) @(negedge clk_in);
		cs_n_out = 1'b1; // frame end set by bit count
		sio_out = ~sio_out; // driven inverted, no stale value
		repeat (40) @(negedge clk_in); // long deselect gap
	endtask
endmodule // sfpbm_host

/* bench/sfpbm_chk_sva.sv */
`timescale 1ns/10ps
module sfpbm_chk (
	input wire clk_in,
	input wire rstn_in,
	input wire cs_n_in,
	input wire prot_level_b3_in,
	input wire prot_level_b2_in,
	input wire prot_level_b1_in,
	input wire prot_level_b0_in,
	input wire top_bottom_sel_in,
	input wire factory_lock_in,
	input wire [3:0] sio_oe_out,
	input wire active_out,
	input wire read_req_out,
	input wire prog_req_out,
	input wire erase_req_out,
	input wire otp_sel_out,
	input wire [23:0] addr_out,
	input wire [11:0] sector_out,
	input wire [8:0] blk32_out,
	input wire [7:0] blk64_out,
	input wire write_enable_latch_out,
	input wire quad_command_mode_out,
	input wire secure_mode_out,
	input wire [7:0] security_reg_out
);
	wire [3:0] lvl = {prot_level_b3_in, prot_level_b2_in,
		prot_level_b1_in, prot_level_b0_in};
	wire [8:0] n = 9'h1 << (lvl - 4'h1);
	// target block lies in the locked range
	wire hit = lvl > 4'h8 || (lvl != 4'h0 && (top_bottom_sel_in ?
		{1'b0, blk64_out} < n : {1'b0, blk64_out} >= 9'h100 - n));
	wire wr = prog_req_out || erase_req_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	property p_rst;
		$rose(rstn_in) |-> !quad_command_mode_out && !secure_mode_out;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset mode");
	property p_dec;
		$stable(addr_out) [*3] |-> sector_out == addr_out[23:12] &&
			blk32_out == addr_out[23:15] && blk64_out == addr_out[23:16];
	endproperty
	a_dec: assert property (p_dec) else $error("bad decode");
	property p_fac;
		$stable(factory_lock_in) [*3] |->
			security_reg_out[0] == factory_lock_in;
	endproperty
	a_fac: assert property (p_fac) else $error("bad lock bit");
	property p_idle;
		cs_n_in [*8] |-> !active_out && sio_oe_out == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("not idle");
	property p_wel;
		wr |-> $past(write_enable_latch_out);
	endproperty
	a_wel: assert property (p_wel) else $error("no latch");
	property p_prot;
		wr && !otp_sel_out |-> !hit;
	endproperty
	a_prot: assert property (p_prot) else $error("locked hit");
	property p_otp;
		(read_req_out || prog_req_out) |-> otp_sel_out == secure_mode_out;
	endproperty
	a_otp: assert property (p_otp) else $error("array in otp");
	property p_quad;
		$changed(quad_command_mode_out) |-> cs_n_in;
	endproperty
	a_quad: assert property (p_quad) else $error("mode mid frame");
endmodule // sfpbm_chk
bind sfpbm_core sfpbm_chk i_sfpbm_chk (.*);

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic tsel = 1'b0;
	logic flock = 1'b0;
	logic busy = 1'b0;
	int k;
	wire sclk, cs_n, act, rej, rd, pg, er, otp, write_enable_latch, quad, sec;
	wire [3:0] sio, sio_o, sio_oe;
	wire [1:0] ek;
	wire [23:0] addr;
	wire [11:0] sect;
	wire [8:0] b32;
	wire [7:0] b64, sreg;
	int fails = 0;
	int samples_checked = 0;
	logic [25:0] q[$];
	logic [25:0] e;
	logic [23:0] a;
	always #2.5 clk_in = ~clk_in;
	sfpbm_host i_sfpbm_host (.clk_in(clk_in), .sio_in(sio_o), .sclk_out(sclk),
		.cs_n_out(cs_n), .sio_out(sio));
	sfpbm_core i_sfpbm_core (.clk_in(clk_in), .rstn_in(rstn_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .sio_in(sio),
		.prot_level_b3_in(lvl[3]), .prot_level_b2_in(lvl[2]),
		.prot_level_b1_in(lvl[1]), .prot_level_b0_in(lvl[0]),
		.top_bottom_sel_in(tsel), .factory_lock_in(flock),
		.busy_flag_in(busy), .sio_out(sio_o), .sio_oe_out(sio_oe),
		.active_out(act), .reject_out(rej), .read_req_out(rd),
		.prog_req_out(pg), .erase_req_out(er), .erase_kind_out(ek),
		.otp_sel_out(otp), .addr_out(addr), .sector_out(sect),
		.blk32_out(b32), .blk64_out(b64), .write_enable_latch_out(write_enable_latch),
		.quad_command_mode_out(quad), .secure_mode_out(sec),
		.security_reg_out(sreg));
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// expected lock decision, worked out from level and select
	function automatic logic hit(logic [3:0] l, logic t, logic [7:0] b);
		logic [8:0] n;
		n = 9'h1 << (l - 4'h1);
		return l > 4'h8 || (l != 4'h0 && (t ? {1'b0, b} < n :
			{1'b0, b} >= 9'h100 - n));
	endfunction
	// result watcher: oldest note against each pulse
	// looked at mid-cycle, clear of the edge that launches it
	always @(negedge clk_in) if ((rej | rd | pg | er) === 1'b1) begin
		if (q.size() == 0)
			chk(1'b0, "unexpected result");
		else begin
			e = q.pop_front();
			chk(e[25:24] === (rd ? 2'h1 : pg ? 2'h2 : er ? 2'h3 : 2'h0) &&
				(e[25:24] == 2'h0 || e[23:0] === addr), "result");
		end
	end
	initial begin
		a = $urandom(32'h7124);
		repeat (16) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (8) @(negedge clk_in);
		chk(quad === 1'b0 && sec === 1'b0, "reset mode");
		flock = 1'b1;
		repeat (5) @(negedge clk_in);
		chk(sreg[0] === 1'b1, "factory bit");
		$display("test reset done");
		for (int l = 0; l < 16; l++) begin
			lvl = l;
			tsel = $urandom;
			a = $urandom;
			i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
			chk(write_enable_latch === 1'b1, "latch set");
			if (!hit(lvl, tsel, a[23:16]))
				q.push_back({2'h3, a});
			k = $urandom_range(2, 0);
			i_sfpbm_host.xfer({(k == 0) ? 8'h20 : (k == 1) ? 8'h52 : 8'hd8,
				a, 8'h0}, 32, 1);
			chk(q.size() == 0 && (hit(lvl, tsel, a[23:16]) ||
				ek === k[1:0]), "erase outcome");
		end
		$display("test levels done");
		lvl = 4'h0;
		i_sfpbm_host.xfer({8'h04, 32'h0}, 8, 1);
		i_sfpbm_host.xfer({8'h02, a, 8'h5a}, 40, 1);
		chk(write_enable_latch === 1'b0 && q.size() == 0, "unlatched prog");
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
		q.push_back({2'h2, a});
		i_sfpbm_host.xfer({8'h02, a, 8'h5a}, 40, 1);
		chk(write_enable_latch === 1'b0 && q.size() == 0, "prog");
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
		q.push_back(26'h0);
		i_sfpbm_host.xfer({8'h20, a, 8'h0}, 25, 1);
		chk(write_enable_latch === 1'b1 && q.size() == 0, "odd length");
		lvl = 4'h1;
		i_sfpbm_host.xfer({8'h60, 32'h0}, 8, 1);
		chk(write_enable_latch === 1'b1 && q.size() == 0, "chip erase locked");
		lvl = 4'h0;
		q.push_back({2'h3, a});
		i_sfpbm_host.xfer({8'hc7, 32'h0}, 8, 1);
		chk(ek === 2'h3 && write_enable_latch === 1'b0 &&
			q.size() == 0, "chip erase");
		q.push_back(26'h0);
		i_sfpbm_host.xfer({8'hf5, 32'h0}, 8, 1);
		chk(act === 1'b0 && sio_oe === 4'h0 && q.size() == 0, "bad op");
		a = $urandom;
		q.push_back({2'h1, a});
		i_sfpbm_host.xfer({8'h03, a, 8'h0}, 32, 1);
		chk(sect === a[23:12] && b32 === a[23:15] && b64 === a[23:16] &&
			q.size() == 0, "decode");
		$display("test commands done");
		busy = 1'b1;
		i_sfpbm_host.xfer({8'h03, a, 8'h0}, 32, 1);
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
		i_sfpbm_host.xfer({8'hd8, a, 8'h0}, 32, 1);
		chk(write_enable_latch === 1'b1 && q.size() == 0, "busy");
		busy = 1'b0; // host sees ready before next command
		$display("test busy done");
		i_sfpbm_host.xfer({8'hb1, 32'h0}, 8, 1);
		chk(sec === 1'b1, "secure on");
		a = $urandom;
		a[9] = 1'b0;
		q.push_back({2'h2, a});
		i_sfpbm_host.xfer({8'h02, a, 8'h5a}, 40, 1);
		chk(otp === 1'b1 && q.size() == 0, "otp prog");
		a[9] = 1'b1;
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
		i_sfpbm_host.xfer({8'h02, a, 8'h5a}, 40, 1);
		chk(write_enable_latch === 1'b1 && q.size() == 0, "factory locked");
		i_sfpbm_host.xfer({8'h2f, 32'h0}, 8, 1);
		chk(sreg[1] === 1'b1 && write_enable_latch === 1'b0, "customer lock");
		a[9] = 1'b0;
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 1);
		i_sfpbm_host.xfer({8'h02, a, 8'h5a}, 40, 1);
		i_sfpbm_host.xfer({8'hd8, a, 8'h0}, 32, 1);
		chk(write_enable_latch === 1'b1 && q.size() == 0, "customer locked");
		q.push_back({2'h1, a});
		i_sfpbm_host.xfer({8'h03, a, 8'h0}, 32, 1);
		chk(otp === 1'b1 && q.size() == 0, "otp read");
		i_sfpbm_host.xfer({8'h2b, 32'h0}, 16, 1);
		chk(i_sfpbm_host.rx_byte === 8'h03, "security read");
		i_sfpbm_host.xfer({8'h2b, 32'h0}, 12, 1);
		chk(act === 1'b0 && sio_oe === 4'h0 &&
			q.size() == 0, "cut read");
		i_sfpbm_host.xfer({8'hc1, 32'h0}, 8, 1);
		chk(sec === 1'b0, "secure off");
		$display("test secure done");
		i_sfpbm_host.xfer({8'h35, 32'h0}, 8, 1);
		chk(quad === 1'b1, "quad on");
		i_sfpbm_host.xfer({8'h06, 32'h0}, 8, 4);
		q.push_back({2'h3, a});
		i_sfpbm_host.xfer({8'hd8, a, 8'h0}, 32, 4);
		chk(ek === 2'h2 && q.size() == 0, "quad erase");
		i_sfpbm_host.xfer({8'h2b, 32'h0}, 16, 4);
		chk(i_sfpbm_host.rx_byte === 8'h03, "quad read");
		i_sfpbm_host.xfer({8'hf5, 32'h0}, 8, 4);
		chk(quad === 1'b0, "quad off");
		$display("test modes done");
		tally_and_finish();
	end
	// hang guard, counted as a mismatch
	initial begin
		#500000;
		fails++;
		tally_and_finish();
	end
endmodule // tb_top
